/* hw/port_diag_control.v */
`timescale 1ns/1ps
`include "port_diag_map.vh"
module port_diag_control #(
  parameter DW = 36,
  parameter AW = 12
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_bus_reset,
  input wire [3:0] i_addr,
  input wire [DW-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [DW-1:0] o_rdata,
  input wire i_data_out,
  input wire i_data_in,
  input wire [DW-1:0] i_host_data,
  output reg [DW-1:0] o_host_data,
  input wire i_bus_parity_err,
  input wire i_ram_parity_err,
  input wire i_port_side_rd,
  input wire i_mp_halt,
  output wire [DW-1:0] o_port_csr,
  output wire o_running,
  output wire o_mp_enable,
  output wire o_irq
);
  reg loopback_reg;
  reg force_pe_reg;
  reg sel_lar_reg;
  reg single_reg;
  reg bus_pe_reg;
  reg ram_pe_reg;
  reg run_reg;
  reg step_pend_reg;
  reg [AW-1:0] rar_reg;
  reg [AW-1:0] lar_reg;
  reg [DW-1:0] buf_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_mask_reg;
  reg [DW-1:0] csr_host;
  wire rst_busy;
  wire rst_clear;
  wire [AW-1:0] next_addr;
  wire step_done;
  wire csr_wr;
  wire start_reset;
  wire step_go;
  wire soft_clear;
  wire halt_evt;
  wire pe_evt;

  assign csr_wr = i_wr && (i_addr == `ADDR_CSR);
  assign start_reset = csr_wr && i_wdata[`BIT_PORT_RESET];
  assign soft_clear = start_reset || rst_clear || i_bus_reset;
  assign step_go = run_reg && single_reg && step_pend_reg;

  reset_sequencer u_rst (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_start(start_reset),
    .o_busy(rst_busy),
    .o_clear(rst_clear)
  );

  microcycle_unit #(.AW(AW)) u_mc (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_clear(soft_clear),
    .i_step(step_go),
    .i_fetch_addr(rar_reg),
    .o_next_addr(next_addr),
    .o_done(step_done)
  );

  assign halt_evt = run_reg && (i_mp_halt || step_done);
  assign pe_evt = i_bus_parity_err ||
    (csr_wr && i_wdata[`BIT_FORCE_PE]);
  assign o_running = run_reg;
  assign o_mp_enable = run_reg && !single_reg && !rst_busy;
  assign o_irq = |(irq_stat_reg & irq_mask_reg);
  // Port side never sees the identity bit
  assign o_port_csr = csr_host & ~({{(DW-1){1'b0}}, 1'b1}
    << `BIT_IDENT_TOP);

  always @* begin
    csr_host = {DW{1'b0}};
    csr_host[`BIT_IDENT_TOP] = 1'b1;
    csr_host[`BIT_PORT_RESET] = rst_busy;
    csr_host[`BIT_LOOPBACK] = loopback_reg;
    csr_host[`BIT_FORCE_PE] = force_pe_reg;
    csr_host[`BIT_SEL_LAR] = sel_lar_reg;
    csr_host[`BIT_SINGLE_CYC] = single_reg;
    csr_host[`BIT_BUS_PE] = bus_pe_reg;
    csr_host[`BIT_RAM_PE] = ram_pe_reg;
    csr_host[`BIT_RUN] = run_reg;
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n || soft_clear) begin
      loopback_reg <= 1'b0;
      force_pe_reg <= 1'b0;
      sel_lar_reg <= 1'b0;
      single_reg <= 1'b0;
      run_reg <= 1'b0;
      step_pend_reg <= 1'b0;
      rar_reg <= {AW{1'b0}};
      lar_reg <= {AW{1'b0}};
    end else begin
      if (csr_wr) begin
        loopback_reg <= i_wdata[`BIT_LOOPBACK];
        force_pe_reg <= i_wdata[`BIT_FORCE_PE];
        sel_lar_reg <= i_wdata[`BIT_SEL_LAR];
        single_reg <= i_wdata[`BIT_SINGLE_CYC];
      end
      if (halt_evt) begin
        run_reg <= 1'b0;
        step_pend_reg <= 1'b0;
      end else if (csr_wr && i_wdata[`BIT_RUN] && !ram_pe_reg) begin
        run_reg <= 1'b1;
        step_pend_reg <= 1'b1;
      end else if (step_go) begin
        step_pend_reg <= 1'b0;
      end
      if (step_done) begin
        lar_reg <= next_addr;
      end
      // Host reloads RAM_ADDRESS_REGISTER before each further step
      if (i_wr && i_addr == `ADDR_RAR) begin
        rar_reg <= i_wdata[AW-1:0];
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n || soft_clear) begin
      bus_pe_reg <= 1'b0;
      ram_pe_reg <= 1'b0;
    end else begin
      if (pe_evt) begin
        bus_pe_reg <= 1'b1;
      end else if (csr_wr && i_wdata[`BIT_BUS_PE]) begin
        bus_pe_reg <= 1'b0;
      end
      if (i_ram_parity_err) begin
        ram_pe_reg <= 1'b1;
      end else if (csr_wr && i_wdata[`BIT_BUS_PE]) begin
        ram_pe_reg <= 1'b0;
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      buf_reg <= {DW{1'b0}};
    end else if (i_data_out && loopback_reg && !run_reg) begin
      buf_reg <= i_host_data;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_host_data <= {DW{1'b0}};
    end else if (i_data_in && !run_reg) begin
      if (loopback_reg) begin
        o_host_data <= buf_reg;
      end else if (sel_lar_reg) begin
        o_host_data <= {{(DW-AW-1){1'b0}}, lar_reg, 1'b0};
      end else begin
        o_host_data <= {DW{1'b0}};
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
    end else begin
      // Set wins over read clear
      irq_stat_reg <= ((i_rd && i_addr == `ADDR_IRQ_STAT) ? 2'h0 :
        irq_stat_reg) | {pe_evt, halt_evt};
      if (i_wr && i_addr == `ADDR_IRQ_MASK) begin
        irq_mask_reg <= i_wdata[1:0];
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= {DW{1'b0}};
    end else if (i_rd) begin
      case (i_addr)
        `ADDR_CSR: o_rdata <= i_port_side_rd ? o_port_csr : csr_host;
        `ADDR_LAR: o_rdata <= {{(DW-AW){1'b0}}, lar_reg};
        `ADDR_RAR: o_rdata <= {{(DW-AW){1'b0}}, rar_reg};
        `ADDR_BUF: o_rdata <= buf_reg;
        `ADDR_IRQ_STAT: o_rdata <= {{(DW-2){1'b0}}, irq_stat_reg};
        `ADDR_IRQ_MASK: o_rdata <= {{(DW-2){1'b0}}, irq_mask_reg};
        default: o_rdata <= {DW{1'b0}};
      endcase
    end else begin
      o_rdata <= {DW{1'b0}};
    end
  end
endmodule // port_diag_control

/* hw/port_diag_map.vh */
// Overview of operation
// - Identity top bit reads one to host, zero from port side.
// - Host writing port reset halts microprocessor and resets control state.
// - Port reset bit clears itself after the reset sequence finishes.
// - Loopback set, not running: data-out loads buffer, data-in returns it.
// - Diagnostic bits set by host one; cleared by zero, port reset, bus reset.
// - Forced parity bit sets bus parity error flag on same control-out.
// - Latch address select, not running, no loopback: data-in returns latch address shifted up one bit.
// - Single-cycle set and run set: execute one microcycle then halt.
// - Run flag clears whenever the microprocessor halts.
// - Single cycle fetches from RAM address, stores next address in latch.
// - Writing one to bus parity flag clears it and microcode RAM parity flag.
`ifndef PORT_DIAG_MAP_VH
`define PORT_DIAG_MAP_VH
`define ADDR_CSR 4'h0
`define ADDR_LAR 4'h1
`define ADDR_RAR 4'h2
`define ADDR_BUF 4'h3
`define ADDR_IRQ_STAT 4'h4
`define ADDR_IRQ_MASK 4'h5
`define BIT_IDENT_TOP 17
`define BIT_PORT_RESET 18
`define BIT_LOOPBACK 19
`define BIT_FORCE_PE 20
`define BIT_SEL_LAR 21
`define BIT_SINGLE_CYC 22
`define BIT_BUS_PE 24
`define BIT_RAM_PE 25
`define BIT_RUN 32
`define RESET_CYCLES 4'h4
`define IRQ_HALT 0
`define IRQ_PE 1
`endif

/* hw/reset_sequencer.v */
`timescale 1ns/1ps
`include "port_diag_map.vh"
module reset_sequencer (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_start,
  output wire o_busy,
  output wire o_clear
);
  reg [3:0] count_reg;
  reg [3:0] count_next;
  always @* begin
    count_next = count_reg;
    if (i_start) begin
      count_next = `RESET_CYCLES;
    end else if (count_reg != 4'h0) begin
      count_next = count_reg - 4'h1;
    end
  end
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      count_reg <= 4'h0;
    end else begin
      count_reg <= count_next;
    end
  end
  assign o_busy = (count_reg != 4'h0);
  assign o_clear = o_busy;
endmodule // reset_sequencer

/* hw/microcycle_unit.v */
`timescale 1ns/1ps
`include "port_diag_map.vh"
module microcycle_unit #(
  parameter AW = 12
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_clear,
  input wire i_step,
  input wire [AW-1:0] i_fetch_addr,
  output reg [AW-1:0] o_next_addr,
  output reg o_done
);
  // Microcycle model: next address is fetch address plus one
  always @(posedge i_sys_clk) begin
    if (!i_rst_n || i_clear) begin
      o_next_addr <= {AW{1'b0}};
      o_done <= 1'b0;
    end else begin
      o_done <= i_step;
      if (i_step) begin
        o_next_addr <= i_fetch_addr + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // microcycle_unit

/* verif/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire i_sys_clk,
  output reg o_data_out,
  output reg o_data_in,
  output reg [35:0] o_host_data
);
  // Never touches microcode RAM, so single-cycle is no hazard
  initial begin
    o_data_out = 1'b0;
    o_data_in = 1'b0;
    o_host_data = 36'h0;
  end
  // Released bus shows inverse, not a stale copy
  task dout(input [35:0] v);
    @(posedge i_sys_clk);
    o_data_out <= 1'b1;
    o_host_data <= v;
    @(posedge i_sys_clk);
    o_data_out <= 1'b0;
    o_host_data <= ~v;
  endtask
  task din;
    @(posedge i_sys_clk);
    o_data_in <= 1'b1;
    @(posedge i_sys_clk);
    o_data_in <= 1'b0;
  endtask
endmodule // host_model

/* verif/port_diag_assertions.sv */
`timescale 1ns/1ps
module port_diag_checker #(
  parameter DW = 36
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_bus_reset,
  input wire [3:0] i_addr,
  input wire [DW-1:0] i_wdata,
  input wire i_wr,
  input wire i_port_side_rd,
  input wire i_bus_parity_err,
  input wire i_ram_parity_err,
  input wire [DW-1:0] o_port_csr,
  input wire o_running,
  input wire o_mp_enable
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire cw = i_wr && i_addr == 4'h0;
  sequence s_clr; cw && i_wdata[18]; endsequence
  sequence s_go;
    cw && i_wdata[32] && i_wdata[22] && !o_port_csr[25] && !o_port_csr[18];
  endsequence
  sequence s_done; o_running ##[1:4] !o_running; endsequence
  AST_IDENT: assert property (i_port_side_rd |-> !o_port_csr[17])
    else $error("identity bit seen from port side");
  AST_RST_RUN: assert property (s_clr |=> !o_running && !o_mp_enable)
    else $error("port reset left the engine running");
  AST_RST_HOLD: assert property (s_clr |=> o_port_csr[18] [*4] ##1 !o_port_csr[18])
    else $error("port reset bit timing wrong");
  AST_RST_DIAG: assert property (s_clr |=> ##4 !(|o_port_csr[21:19]))
    else $error("port reset left diagnostic bits");
  AST_BUS_RST: assert property (i_bus_reset |=> !(|o_port_csr[21:19]) && !o_running)
    else $error("bus reset left diagnostic bits");
  AST_SET_WR: assert property ($rose(o_port_csr[19]) |-> $past(cw && i_wdata[19]))
    else $error("loopback bit set without write");
  AST_FORCE_PE: assert property (cw && i_wdata[20] && !i_wdata[18] |=> o_port_csr[24])
    else $error("forced parity did not set flag");
  AST_PE_CLR: assert property (cw && i_wdata[24] && !i_wdata[20] && !i_bus_parity_err
    && !i_ram_parity_err |=> !(|o_port_csr[25:24]))
    else $error("parity flags not cleared");
  AST_STEP: assert property (s_go |=> s_done)
    else $error("single step did not halt");
  AST_STEP_EN: assert property (o_port_csr[22] |-> !o_mp_enable)
    else $error("free run while single-cycle set");
endmodule // port_diag_checker
bind port_diag_control port_diag_checker #(.DW(DW)) chk_i (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_bus_reset(i_bus_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_port_side_rd(i_port_side_rd), .i_bus_parity_err(i_bus_parity_err),
  .i_ram_parity_err(i_ram_parity_err), .o_port_csr(o_port_csr),
  .o_running(o_running), .o_mp_enable(o_mp_enable));

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
  reg i_sys_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg i_bus_reset = 1'b0;
  reg [3:0] i_addr = 4'h0;
  reg [35:0] i_wdata = 36'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg i_bpe = 1'b0;
  reg i_rpe = 1'b0;
  reg i_port_side_rd = 1'b0;
  reg i_mp_halt = 1'b0;
  wire [35:0] o_rdata, o_host_data, o_port_csr, hd;
  wire o_running, o_mp_enable, o_irq, dout, din;
  reg [35:0] rv;
  integer n_mismatch = 0;
  integer checks_done = 0;
  integer cyc = 0;
  host_model host (.i_sys_clk(i_sys_clk), .o_data_out(dout), .o_data_in(din),
    .o_host_data(hd));
  port_diag_control dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_bus_reset(i_bus_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_data_out(dout), .i_data_in(din),
    .i_host_data(hd), .o_host_data(o_host_data), .i_bus_parity_err(i_bpe),
    .i_ram_parity_err(i_rpe), .i_port_side_rd(i_port_side_rd),
    .i_mp_halt(i_mp_halt), .o_port_csr(o_port_csr), .o_running(o_running),
    .o_mp_enable(o_mp_enable), .o_irq(o_irq));
  initial forever #50 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end
  task chk(input [35:0] seen, input [35:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wr(input [3:0] a, input [35:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task pulse_ev(input integer w);
    @(posedge i_sys_clk);
    if (w == 0) i_rpe <= 1'b1;
    else i_mp_halt <= 1'b1;
    @(posedge i_sys_clk);
    i_rpe <= 1'b0;
    i_mp_halt <= 1'b0;
  endtask
  task t_ident;
    rd(4'h0);
    chk(rv & 36'h20000, 36'h20000);
    @(posedge i_sys_clk);
    i_port_side_rd <= 1'b1;
    @(posedge i_sys_clk);
    #1 chk(o_port_csr & 36'h20000, 36'h0);
    rd(4'h0);
    chk(rv & 36'h20000, 36'h0);
    @(posedge i_sys_clk);
    i_port_side_rd <= 1'b0;
  endtask
  task t_loop;
    wr(4'h0, 36'h80000);
    host.dout(36'h9a5a5a5a5);
    host.din;
    #1 chk(o_host_data, 36'h9a5a5a5a5);
    wr(4'h0, 36'h0);
    rd(4'h0);
    chk(rv & 36'h380000, 36'h0);
  endtask
  task t_step;
    wr(4'h2, 36'h5);
    wr(4'h0, 36'h100400000);
    repeat (4) @(posedge i_sys_clk);
    #1 chk({35'h0, o_running}, 36'h0);
    rd(4'h1);
    chk(rv, 36'h6);
    wr(4'h2, rv);
    wr(4'h0, 36'h200000);
    host.din;
    #1 chk(o_host_data & 36'h1ffe, 36'hc);
    wr(4'h0, 36'h100400000);
    repeat (4) @(posedge i_sys_clk);
    rd(4'h1);
    chk(rv, 36'h7);
  endtask
  task t_pe;
    wr(4'h5, 36'h2);
    wr(4'h0, 36'h100000);
    rd(4'h0);
    chk(rv & 36'h1000000, 36'h1000000);
    chk({35'h0, o_irq}, 36'h1);
    rd(4'h4);
    chk(rv & 36'h3, 36'h3);
    chk({35'h0, o_irq}, 36'h0);
    pulse_ev(0);
    rd(4'h0);
    chk(rv & 36'h2000000, 36'h2000000);
    wr(4'h0, 36'h1000000);
    rd(4'h0);
    chk(rv & 36'h3000000, 36'h0);
    wr(4'h5, 36'h1);
    wr(4'h0, 36'h100000000);
    #1 chk({35'h0, o_mp_enable}, 36'h1);
    pulse_ev(1);
    #1 chk({35'h0, o_running}, 36'h0);
    chk({35'h0, o_irq}, 36'h1);
    rd(4'h4);
    chk(rv & 36'h3, 36'h1);
    chk({35'h0, o_irq}, 36'h0);
  endtask
  task t_reset;
    wr(4'h0, 36'h280000);
    wr(4'h0, 36'h2c0000);
    rd(4'h0);
    chk(rv & 36'h40000, 36'h40000);
    repeat (4) @(posedge i_sys_clk);
    rd(4'h0);
    chk(rv & 36'h3c0000, 36'h0);
    rd(4'h1);
    chk(rv, 36'h0);
    wr(4'h0, 36'h80000);
    @(posedge i_sys_clk);
    i_bus_reset <= 1'b1;
    @(posedge i_sys_clk);
    i_bus_reset <= 1'b0;
    rd(4'h0);
    chk(rv & 36'h80000, 36'h0);
  endtask
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    t_ident;
    t_loop;
    t_step;
    t_pe;
    t_reset;
    stop_test;
  end
endmodule // tb
